// ---- hdl/cac_ctrl.sv ----
/*
  Control register of a programmable counter array with six capture/compare
  modules: run control, overflow flag and six module event flags, reached
  as a byte and bit-addressable special-function register.
  Assumes the counter datapath, module logic and watchdog enable sit on the
  same system clock and deliver one-cycle event pulses.
*/
// What this block does
// - The overflow flag sets whenever the 16-bit counter wraps from its top count to zero.
// - With the overflow interrupt enabled, a set overflow flag raises the shared interrupt.
// - Only a software write of zero ever clears the overflow flag.
// - The run bit stops the counter at zero and lets it count at one.
// - Each of the six modules sets its own event flag on a match or capture, module n at bit n.
// - With a module's interrupt enabled, its set event flag raises the shared interrupt.
// - Only a software write of zero ever clears a module event flag.
// - The register sits at address 0xd8 on page 0x00, bit-addressable, all bits read/write, reset zero.
// - A write of one to the module 5 flag while the watchdog is on forces a watchdog reset.
// - While the watchdog is on, run-bit writes are ignored, the counter keeps running, and the bit reads as stored.
`timescale 1ns/100ps
module cac_ctrl
  import cac_pkg::*;
#(
  parameter int NUM_MOD = CAC_NUM_MOD
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Register port from the CPU
  input  wire cac_sfr_req_t       sfr_req_i,
  output logic [7:0]              sfr_rdata_o,
  // Counter and module events
  input  wire logic               counter_wrap_i,
  input  wire logic [NUM_MOD-1:0] module_event_i,
  // Interrupt enables and watchdog state
  input  wire logic               overflow_irq_en_i,
  input  wire logic [NUM_MOD-1:0] module_irq_en_i,
  input  wire logic               watchdog_enable_i,
  // Outputs to the counter, CPU and reset logic
  output logic                    counter_run_o,
  output logic                    counter_array_irq_o,
  output logic                    watchdog_reset_o
);

  // Byte register hit on address and page
  function automatic logic cac_byte_hit(input logic [7:0] addr, input logic [7:0] page);
    return (addr == CAC_CTRL_ADDR) && (page == CAC_CTRL_PAGE);
  endfunction

  logic [7:0] wr_en;
  logic [7:0] wr_val;
  logic [7:0] set_vec;
  logic [7:0] counter_array_control;
  logic       counter_run_control;
  logic       next_run_control;
  logic       wdog_force;
  logic [7:0] next_rdata;
  logic       next_irq;
  logic       next_run_out;
  logic       next_wdog_reset;
  logic       byte_hit;

  assign byte_hit = cac_byte_hit(sfr_req_i.addr, sfr_req_i.page);

  always_comb begin
    wr_en  = 8'h00;
    wr_val = sfr_req_i.wdata;
    if (sfr_req_i.wr && byte_hit) begin
      wr_en = 8'hff;
    end else if (sfr_req_i.bit_wr && (sfr_req_i.bit_addr[7:3] == CAC_BIT_BASE) &&
                 (sfr_req_i.page == CAC_CTRL_PAGE)) begin
      wr_en  = 8'h01 << sfr_req_i.bit_addr[2:0];
      wr_val = {8{sfr_req_i.bit_val}};
    end
  end

  assign wdog_force = watchdog_enable_i && wr_en[CAC_WDOG_BIT] && wr_val[CAC_WDOG_BIT];

  // Hardware set sources; the run slot is not a flag
  assign set_vec = {counter_wrap_i, 1'b0, module_event_i};

  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (i == CAC_RUN_BIT) begin : g_run
      assign counter_array_control[i] = counter_run_control;
    end else begin : g_cell
      cac_flag_cell u_cell (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .hw_set_i (set_vec[i]),
        // Forcing a watchdog reset does not also store the one
        .sw_wr_i  (wr_en[i] && !(i == CAC_WDOG_BIT && wdog_force)),
        .sw_val_i (wr_val[i]),
        .flag_o   (counter_array_control[i])
      );
    end
  end

  always_comb begin
    next_run_control = counter_run_control;
    if (wr_en[CAC_RUN_BIT] && !watchdog_enable_i) begin
      next_run_control = wr_val[CAC_RUN_BIT];
    end
  end

  // Output next values; read data holds between reads
  always_comb begin
    next_rdata = sfr_rdata_o;
    if (sfr_req_i.rd) begin
      next_rdata = byte_hit ? counter_array_control : 8'h00;
    end
    next_irq = (counter_array_control[CAC_OVF_BIT] && overflow_irq_en_i) ||
               |(counter_array_control[NUM_MOD-1:0] & module_irq_en_i);
    // counter runs if enabled or watchdog on
    next_run_out    = counter_run_control || watchdog_enable_i;
    next_wdog_reset = wdog_force;
  end

  // Registered state and outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_run_control <= CAC_CTRL_RESET[CAC_RUN_BIT];
      sfr_rdata_o         <= CAC_CTRL_RESET;
      counter_array_irq_o <= 1'b0;
      counter_run_o       <= 1'b0;
      watchdog_reset_o    <= 1'b0;
    end else if (ce_i) begin
      counter_run_control <= next_run_control;
      sfr_rdata_o         <= next_rdata;
      counter_array_irq_o <= next_irq;
      counter_run_o       <= next_run_out;
      watchdog_reset_o    <= next_wdog_reset;
    end
  end

  // Checks
  sequence s_wrap;
    ce_i && counter_wrap_i;
  endsequence

  sequence s_ovf_pending;
    ce_i && overflow_irq_en_i && counter_array_control[CAC_OVF_BIT];
  endsequence

  property p_ovf_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_wrap |=> counter_array_control[CAC_OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set after wrap");

  property p_ovf_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_wrap ##1 s_ovf_pending |=> counter_array_irq_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow did not raise interrupt");

  property p_ovf_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
    counter_array_control[CAC_OVF_BIT] && !(ce_i && wr_en[CAC_OVF_BIT] && !wr_val[CAC_OVF_BIT])
      |=> counter_array_control[CAC_OVF_BIT];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared without write");

  property p_run_out;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !watchdog_enable_i && !counter_run_control |=> !counter_run_o;
  endproperty
  a_run_out: assert property (p_run_out) else $error("counter runs while run bit is zero");

  property p_mod_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && |module_event_i |=>
      ((counter_array_control[NUM_MOD-1:0] & $past(module_event_i)) == $past(module_event_i));
  endproperty
  a_mod_set: assert property (p_mod_set) else $error("module flag not set after event");

  property p_mod_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && |(counter_array_control[NUM_MOD-1:0] & module_irq_en_i) |=> counter_array_irq_o;
  endproperty
  a_mod_irq: assert property (p_mod_irq) else $error("module flag did not raise interrupt");

  property p_mod_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> (($past(counter_array_control[NUM_MOD-1:0]) & ~counter_array_control[NUM_MOD-1:0] &
               ~($past(wr_en[NUM_MOD-1:0]) & ~$past(wr_val[NUM_MOD-1:0]))) == '0);
  endproperty
  a_mod_sticky: assert property (p_mod_sticky) else $error("module flag cleared without write");

  property p_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sfr_req_i.rd && byte_hit |=> sfr_rdata_o == $past(counter_array_control);
  endproperty
  a_read: assert property (p_read) else $error("read data does not match register");

  property p_wdog_force;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wdog_force |=> watchdog_reset_o ##1 (!ce_i || !$past(wdog_force) || watchdog_reset_o);
  endproperty
  a_wdog_force: assert property (p_wdog_force) else $error("watchdog reset not forced");

  property p_wdog_run;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && watchdog_enable_i |=> counter_run_o && (counter_run_control == $past(counter_run_control));
  endproperty
  a_wdog_run: assert property (p_wdog_run) else $error("run bit changed under watchdog");

  property p_set_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && counter_wrap_i && wr_en[CAC_OVF_BIT] && !wr_val[CAC_OVF_BIT]
      |=> counter_array_control[CAC_OVF_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against clear");

endmodule // cac_ctrl

// ---- hdl/cac_flag_cell.sv ----
/*
  One sticky status flag: set by hardware, written by software.
  Assumes the set and write inputs are on the same clock as the cell.
*/
`timescale 1ns/100ps
module cac_flag_cell
  import cac_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Set and write
  input  wire logic hw_set_i,
  input  wire logic sw_wr_i,
  input  wire logic sw_val_i,
  // State
  output logic      flag_o
);

  logic next_flag;

  // A hardware set beats a software clear in the same cycle
  always_comb begin
    next_flag = sw_wr_i ? sw_val_i : flag_o;
    if (hw_set_i) begin
      next_flag = 1'b1;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      flag_o <= next_flag;
    end
  end

endmodule // cac_flag_cell

// ---- hdl/cac_pkg.sv ----
/*
  Package for the counter array control register slice: the register
  address, bit positions, reset value and the register-port request struct.
  Assumes a single system clock shared by the CPU special-function port.
*/
package cac_pkg;

  // Register placement
  localparam logic [7:0] CAC_CTRL_ADDR  = 8'hd8;
  localparam logic [7:0] CAC_CTRL_PAGE  = 8'h00;
  localparam logic [7:0] CAC_CTRL_RESET = 8'h00;

  // Bit positions inside the control register
  localparam int CAC_OVF_BIT  = 7;
  localparam int CAC_RUN_BIT  = 6;
  localparam int CAC_WDOG_BIT = 5;
  localparam int CAC_NUM_MOD  = 6;

  // Bit addresses of this register share the upper five address bits
  localparam logic [4:0] CAC_BIT_BASE = CAC_CTRL_ADDR[7:3];

  // One cycle of special-function register traffic
  typedef struct packed {
    logic       rd;        // Byte read strobe
    logic       wr;        // Byte write strobe
    logic [7:0] addr;      // Byte address
    logic [7:0] page;      // Register page
    logic [7:0] wdata;     // Byte write data
    logic       bit_wr;    // Single-bit write strobe
    logic [7:0] bit_addr;  // Bit address
    logic       bit_val;   // Single-bit write value
  } cac_sfr_req_t;

endpackage : cac_pkg

// ---- testbench/cac_cpu_model.sv ----
/*
  CPU side model: byte and bit accesses on the register port.
  Assumes it is called from the bench; it drives only at falling edges.
*/
`timescale 1ns/100ps
module cac_cpu_model
  import cac_pkg::*;
(
  // Clock
  input  wire logic   clk_i,
  // Register port
  output cac_sfr_req_t req_o
);
  initial req_o = '0;
  // software clears flags
  // One access held for one rising edge, then released;
  // released strobes go low, address, data and bit value lines show inverted values so stale data cannot pass
  task automatic drive(input logic rd, wr, bw, input logic [7:0] a, d, input logic bv);
    @(negedge clk_i);
    req_o = '{rd, wr, a, CAC_CTRL_PAGE, d, bw, a, bv};
    @(negedge clk_i);
    req_o = '{1'b0, 1'b0, ~a, CAC_CTRL_PAGE, ~d, 1'b0, ~a, ~bv};
  endtask
endmodule // cac_cpu_model

// ---- testbench/tb.sv ----
/*
  Testbench for the counter array control register slice.
  Assumes one 40 MHz clock; all inputs change at falling edges.
*/
`timescale 1ns/100ps
module tb;
  import cac_pkg::*;
  logic         clk_i = 1'b0, rst_n_i = 1'b0, wrap = 1'b0, ovf_en = 1'b1, wd_en = 1'b0, ce = 1'b1;
  logic [5:0]   mev = '0, men = '1;
  logic [7:0]   rdata;
  logic         run, irq, wdr;
  cac_sfr_req_t req;
  int           errors = 0, checked = 0;

  // Clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  cac_cpu_model cpu (.clk_i(clk_i), .req_o(req));
  cac_ctrl #(.NUM_MOD(6)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .counter_wrap_i(wrap), .module_event_i(mev), .overflow_irq_en_i(ovf_en),
    .module_irq_en_i(men), .watchdog_enable_i(wd_en), .counter_run_o(run),
    .counter_array_irq_o(irq), .watchdog_reset_o(wdr));

  task automatic check(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp);
    cpu.drive(1'b1, 1'b0, 1'b0, a, 8'h00, 1'b0);
    check(rdata, exp);
  endtask
  task automatic wr(input logic [7:0] a, d);
    cpu.drive(1'b0, 1'b1, 1'b0, a, d, 1'b0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(CAC_CTRL_ADDR, 8'h00);
    wr(8'hd9, 8'hff);
    rd(8'hd9, 8'h00);
    rd(CAC_CTRL_ADDR, 8'h00);
    wr(CAC_CTRL_ADDR, 8'h40);
    @(negedge clk_i);
    check({7'h0, run}, 8'h01);
    rd(CAC_CTRL_ADDR, 8'h40);
    wr(CAC_CTRL_ADDR, 8'h00);
    @(negedge clk_i);
    check({7'h0, run}, 8'h00);
    // Overflow flag sticks until written zero
    @(negedge clk_i) wrap = 1'b1;
    @(negedge clk_i) wrap = 1'b0;
    @(negedge clk_i);
    check({7'h0, irq}, 8'h01);
    repeat (8) @(negedge clk_i);
    rd(CAC_CTRL_ADDR, 8'h80);
    check({7'h0, irq}, 8'h01);
    wr(CAC_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge clk_i);
    check({7'h0, irq}, 8'h00);
    // Every module flag in turn
    for (int n = 0; n < 6; n++) begin
      @(negedge clk_i) mev = 6'(1 << n);
      @(negedge clk_i) mev = '0;
      repeat (4) @(negedge clk_i);
      check({7'h0, irq}, 8'h01);
      rd(CAC_CTRL_ADDR, 8'(1 << n));
      rd(CAC_CTRL_ADDR, 8'(1 << n));
      wr(CAC_CTRL_ADDR, 8'h00);
    end
    // Disabled source must stay quiet
    men = '0;
    @(negedge clk_i) mev = 6'h08;
    @(negedge clk_i) mev = '0;
    repeat (2) @(negedge clk_i);
    check({7'h0, irq}, 8'h00);
    rd(CAC_CTRL_ADDR, 8'h08);
    // Hardware set meets software clear in one edge
    fork
      wr(CAC_CTRL_ADDR, 8'h00);
      begin
        @(negedge clk_i) {mev, wrap} = {6'h04, 1'b1};
        @(negedge clk_i) {mev, wrap} = {6'h00, 1'b0};
      end
    join
    rd(CAC_CTRL_ADDR, 8'h84);
    // Single-bit clear, then set, of module 2
    cpu.drive(1'b0, 1'b0, 1'b1, 8'hda, 8'h00, 1'b0);
    rd(CAC_CTRL_ADDR, 8'h80);
    cpu.drive(1'b0, 1'b0, 1'b1, 8'hda, 8'h00, 1'b1);
    rd(CAC_CTRL_ADDR, 8'h84);
    wr(CAC_CTRL_ADDR, 8'h00);
    // Events are not taken while the clock enable is low
    ce = 1'b0;
    @(negedge clk_i) mev = 6'h02;
    @(negedge clk_i) {mev, ce} = {6'h00, 1'b1};
    rd(CAC_CTRL_ADDR, 8'h00);
    // Watchdog on: run writes dropped, forced reset
    wd_en = 1'b1;
    wr(CAC_CTRL_ADDR, 8'h40);
    repeat (2) @(negedge clk_i);
    check({7'h0, run}, 8'h01);
    rd(CAC_CTRL_ADDR, 8'h00);
    cpu.drive(1'b0, 1'b0, 1'b1, 8'hdd, 8'h00, 1'b1);
    check({7'h0, wdr}, 8'h01);
    @(negedge clk_i);
    check({7'h0, wdr}, 8'h00);
    rd(CAC_CTRL_ADDR, 8'h00);
    print_verdict();
  end
endmodule // tb
